// ### inc/cgp_pkg.sv
package cgp_pkg;
    localparam int GPIO_W = 8;
    localparam int NIB_W = 4;
    localparam int IDX_W = 3;
    localparam int MASK_BITS = 16;
    localparam int CNT_W = 5;
    // register indices
    localparam logic [2:0] IDX_DIR_HI = 3'h0;
    localparam logic [2:0] IDX_DIR_LO = 3'h1;
    localparam logic [2:0] IDX_VAL_HI = 3'h2;
    localparam logic [2:0] IDX_VAL_LO = 3'h3;
    localparam logic [2:0] IDX_IN_HI = 3'h4;
    localparam logic [2:0] IDX_IN_LO = 3'h5;
    // field positions within an 8-bit register
    localparam int SET_LSB = 4;
    localparam int CLR_LSB = 0;
    // values after reset
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] VAL_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [15:0] MASK_RST = 16'h0000;
    // alternate pin positions
    localparam int ALT_CLK_PIN = 0;
    localparam int ALT_LOAD_PIN = 2;
    // shift clock half period in SYS_CLK cycles
    localparam logic [3:0] HALF_CYC = 4'h4;
endpackage

// ### inc/cgp_pin_if.sv
`timescale 1ns/1ps
interface cgp_pin_if;
    logic [7:0] dir_set;
    logic [7:0] dir_clr;
    logic [7:0] val_set;
    logic [7:0] val_clr;
    logic [7:0] dir;
    logic [7:0] val;
    modport ctrl (output dir_set, dir_clr, val_set, val_clr, input dir, val);
    modport bank (input dir_set, dir_clr, val_set, val_clr, output dir, val);
endinterface

// ### src/cgp_pin_bank.sv
`timescale 1ns/1ps
module cgp_pin_bank
    import cgp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    cgp_pin_if.bank pif
);
    // ----------------------------------------
    // per-pin direction and output value
    // ----------------------------------------
    for (genvar k = 0; k < GPIO_W; k++) begin : g_pin
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pif.dir[k] <= DIR_RST[k];
            end else if (ce) begin
                if (pif.dir_set[k]) begin
                    pif.dir[k] <= 1'b1;
                end else if (pif.dir_clr[k]) begin
                    pif.dir[k] <= 1'b0;
                end
            end
        end
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pif.val[k] <= VAL_RST[k];
            end else if (ce) begin
                if (pif.val_set[k]) begin
                    pif.val[k] <= 1'b1;
                end else if (pif.val_clr[k]) begin
                    pif.val[k] <= 1'b0;
                end
            end
        end
    end
endmodule

// ### src/cgp_mask_shift.sv
`timescale 1ns/1ps
module cgp_mask_shift
    import cgp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic active,
    input wire logic ser_in,
    output logic sclk,
    output logic sload,
    output logic [15:0] mask,
    output logic mask_valid
);
    typedef enum logic [2:0] {MS_IDLE, MS_LOAD, MS_LOW, MS_HIGH, MS_DONE} cgp_ms_t;
    cgp_ms_t state_reg;
    logic [3:0] tick_reg;
    logic [4:0] bit_cnt_reg;
    logic [15:0] shift_reg;
    logic tick_end;

    assign tick_end = (tick_reg == HALF_CYC - 4'h1);

    // ----------------------------------------
    // load pulse, then sixteen shift clocks
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= MS_IDLE;
            tick_reg <= 4'h0;
            bit_cnt_reg <= 5'h00;
            sclk <= 1'b0;
            sload <= 1'b1;
        end else if (ce) begin
            tick_reg <= tick_end ? 4'h0 : tick_reg + 4'h1;
            if (!active) begin
                state_reg <= MS_IDLE;
                sclk <= 1'b0;
                sload <= 1'b1;
                tick_reg <= 4'h0;
            end else begin
                case (state_reg)
                    MS_IDLE: begin
                        state_reg <= MS_LOAD;
                        sload <= 1'b0;
                        tick_reg <= 4'h0;
                        bit_cnt_reg <= 5'h00;
                    end
                    MS_LOAD: begin
                        if (tick_end) begin
                            state_reg <= MS_LOW;
                            sload <= 1'b1;
                        end
                    end
                    MS_LOW: begin
                        if (tick_end) begin
                            state_reg <= MS_HIGH;
                            sclk <= 1'b1;
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        end
                    end
                    MS_HIGH: begin
                        if (tick_end) begin
                            sclk <= 1'b0;
                            state_reg <= (bit_cnt_reg == CNT_W'(MASK_BITS)) ? MS_DONE : MS_LOW;
                        end
                    end
                    default: begin
                        state_reg <= MS_DONE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_reg <= MASK_RST;
        end else if (ce && active && state_reg == MS_LOW && tick_end) begin
            shift_reg <= {shift_reg[14:0], ser_in};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask <= MASK_RST;
            mask_valid <= 1'b0;
        end else if (ce && active && state_reg == MS_HIGH && tick_end
                     && bit_cnt_reg == CNT_W'(MASK_BITS)) begin
            mask <= shift_reg;
            mask_valid <= 1'b1;
        end
    end

    a_shift_len: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == MS_DONE |-> bit_cnt_reg == CNT_W'(MASK_BITS))
        else $error("mask shift ended with wrong bit count");
endmodule

// ### src/cgp_top.sv
`timescale 1ns/1ps
// Functional notes
// - eight pins, one bit each per field
// - 8-bit registers: upper set, lower clear
// - direction set one makes pin output
// - direction clear one floats pin driver
// - zeros written leave pin state unchanged
// - after reset all pins are inputs
// - value set one drives pin high
// - value clear one drives pin low
// - value driven only while pin outputs
// - stored output values reset to zero
// - input level read-only, live pin levels
// - registers reachable from both bus sides
// - primary reset: pin 0 is shift clock
// - primary reset: pin 2 is shift/load
// - shift in 16-bit clock-disable mask
module cgp_top
    import cgp_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic PRIMARY_RESET_INPUT_N,
    input wire logic MASK_SERIAL_INPUT,
    input wire logic [7:0] GPIO_IN,
    output logic [7:0] GPIO_OUT,
    output logic [7:0] GPIO_OE,
    input wire logic PRI_CFG_WR,
    input wire logic PRI_CFG_RD,
    input wire logic [2:0] PRI_CFG_IDX,
    input wire logic [7:0] PRI_CFG_WDATA,
    output logic [7:0] PRI_CFG_RDATA,
    input wire logic SEC_CFG_WR,
    input wire logic SEC_CFG_RD,
    input wire logic [2:0] SEC_CFG_IDX,
    input wire logic [7:0] SEC_CFG_WDATA,
    output logic [7:0] SEC_CFG_RDATA,
    output logic [15:0] CLOCK_DISABLE_MASK,
    output logic MASK_VALID
);
    cgp_pin_if pif();

    logic alt_mode;
    logic m_sclk;
    logic m_sload;
    logic [15:0] m_mask;
    logic m_valid;
    logic [7:0] out_next;
    logic [7:0] oe_next;
    logic [7:0] pri_rd_next;
    logic [7:0] sec_rd_next;
    logic [7:0] dir_set;
    logic [7:0] dir_clr;
    logic [7:0] val_set;
    logic [7:0] val_clr;
    logic [1:0] side_wr;
    logic [2:0] side_idx [2];
    logic [7:0] side_wd [2];

    assign alt_mode = !PRIMARY_RESET_INPUT_N;

    // ----------------------------------------
    // write decode, both bus sides
    // ----------------------------------------
    assign side_wr = {SEC_CFG_WR, PRI_CFG_WR};
    assign side_idx[0] = PRI_CFG_IDX;
    assign side_idx[1] = SEC_CFG_IDX;
    assign side_wd[0] = PRI_CFG_WDATA;
    assign side_wd[1] = SEC_CFG_WDATA;

    always_comb begin
        dir_set = 8'h00;
        dir_clr = 8'h00;
        val_set = 8'h00;
        val_clr = 8'h00;
        for (int s = 0; s < 2; s++) begin
            if (side_wr[s]) begin
                // upper nibble sets, lower nibble clears; zero bits do nothing
                if (side_idx[s] == IDX_DIR_HI) begin
                    dir_set[7:4] = dir_set[7:4] | side_wd[s][7:SET_LSB];
                    dir_clr[7:4] = dir_clr[7:4] | side_wd[s][3:CLR_LSB];
                end else if (side_idx[s] == IDX_DIR_LO) begin
                    dir_set[3:0] = dir_set[3:0] | side_wd[s][7:SET_LSB];
                    dir_clr[3:0] = dir_clr[3:0] | side_wd[s][3:CLR_LSB];
                end else if (side_idx[s] == IDX_VAL_HI) begin
                    val_set[7:4] = val_set[7:4] | side_wd[s][7:SET_LSB];
                    val_clr[7:4] = val_clr[7:4] | side_wd[s][3:CLR_LSB];
                end else if (side_idx[s] == IDX_VAL_LO) begin
                    val_set[3:0] = val_set[3:0] | side_wd[s][7:SET_LSB];
                    val_clr[3:0] = val_clr[3:0] | side_wd[s][3:CLR_LSB];
                end
            end
        end
    end

    assign pif.dir_set = dir_set;
    assign pif.dir_clr = dir_clr;
    assign pif.val_set = val_set;
    assign pif.val_clr = val_clr;

    // ----------------------------------------
    // pin state storage
    // ----------------------------------------
    cgp_pin_bank u_bank (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .ce(CLK_EN),
        .pif(pif.bank)
    );

    // ----------------------------------------
    // reset-time mask shifter
    // ----------------------------------------
    cgp_mask_shift u_shift (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .ce(CLK_EN),
        .active(alt_mode),
        .ser_in(MASK_SERIAL_INPUT),
        .sclk(m_sclk),
        .sload(m_sload),
        .mask(m_mask),
        .mask_valid(m_valid)
    );

    // ----------------------------------------
    // pin drive with alternate duties
    // ----------------------------------------
    always_comb begin
        out_next = pif.val;
        oe_next = pif.dir;
        if (alt_mode) begin
            out_next[ALT_CLK_PIN] = m_sclk;
            oe_next[ALT_CLK_PIN] = 1'b1;
            out_next[ALT_LOAD_PIN] = m_sload;
            oe_next[ALT_LOAD_PIN] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            GPIO_OUT <= VAL_RST;
            GPIO_OE <= DIR_RST;
        end else if (CLK_EN) begin
            GPIO_OUT <= out_next;
            GPIO_OE <= oe_next;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            CLOCK_DISABLE_MASK <= MASK_RST;
            MASK_VALID <= 1'b0;
        end else if (CLK_EN) begin
            CLOCK_DISABLE_MASK <= m_mask;
            MASK_VALID <= m_valid;
        end
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    function automatic logic [7:0] rd_mux(input logic [2:0] idx,
                                          input logic [7:0] dir,
                                          input logic [7:0] val,
                                          input logic [7:0] pins);
        logic [7:0] r;
        r = 8'h00;
        if (idx == IDX_DIR_HI) begin
            r = {dir[7:4], 4'h0};
        end else if (idx == IDX_DIR_LO) begin
            r = {dir[3:0], 4'h0};
        end else if (idx == IDX_VAL_HI) begin
            r = {val[7:4], 4'h0};
        end else if (idx == IDX_VAL_LO) begin
            r = {val[3:0], 4'h0};
        end else if (idx == IDX_IN_HI) begin
            r = {pins[7:4], 4'h0};
        end else if (idx == IDX_IN_LO) begin
            r = {pins[3:0], 4'h0};
        end
        return r;
    endfunction

    assign pri_rd_next = rd_mux(PRI_CFG_IDX, pif.dir, pif.val, GPIO_IN);
    assign sec_rd_next = rd_mux(SEC_CFG_IDX, pif.dir, pif.val, GPIO_IN);

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            PRI_CFG_RDATA <= RDATA_RST;
        end else if (CLK_EN && PRI_CFG_RD) begin
            PRI_CFG_RDATA <= pri_rd_next;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            SEC_CFG_RDATA <= RDATA_RST;
        end else if (CLK_EN && SEC_CFG_RD) begin
            SEC_CFG_RDATA <= sec_rd_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    a_dir_set_out: assert property (
        CLK_EN |=> ((pif.dir & $past(dir_set)) == $past(dir_set)))
        else $error("direction set bit not applied");

    a_dir_clr_in: assert property (
        CLK_EN |=> ((pif.dir & ($past(dir_clr) & ~$past(dir_set))) == 8'h00))
        else $error("direction clear bit not applied");

    a_zero_keeps_dir: assert property (
        CLK_EN |=> (((pif.dir ^ $past(pif.dir))
                     & ~($past(dir_set) | $past(dir_clr))) == 8'h00))
        else $error("direction changed without a one written");

    a_zero_keeps_val: assert property (
        CLK_EN |=> (((pif.val ^ $past(pif.val))
                     & ~($past(val_set) | $past(val_clr))) == 8'h00))
        else $error("value changed without a one written");

    a_val_set_high: assert property (
        CLK_EN |=> ((pif.val & $past(val_set)) == $past(val_set)))
        else $error("value set bit not applied");

    a_val_clr_low: assert property (
        CLK_EN |=> ((pif.val & ($past(val_clr) & ~$past(val_set))) == 8'h00))
        else $error("value clear bit not applied");

    a_reset_inputs: assert property (
        $rose(RESETN) |-> (pif.dir == 8'h00 && pif.val == 8'h00 && GPIO_OE == 8'h00))
        else $error("pins not inputs after reset");

    a_pin_follow_reg: assert property (
        CLK_EN && !alt_mode |=> (GPIO_OE == $past(pif.dir) && GPIO_OUT == $past(pif.val)))
        else $error("pin drive does not follow registers");

    a_alt_pin_duty: assert property (
        CLK_EN && alt_mode |=> (GPIO_OE[0] && GPIO_OE[2] && GPIO_OUT[0] == $past(m_sclk)
                                && GPIO_OUT[2] == $past(m_sload)))
        else $error("alternate pin duty not driven");

    a_input_read: assert property (
        CLK_EN && PRI_CFG_RD && PRI_CFG_IDX == IDX_IN_LO
        |=> PRI_CFG_RDATA == {$past(GPIO_IN[3:0]), 4'h0})
        else $error("input level read wrong");

    a_sec_side_read: assert property (
        CLK_EN && SEC_CFG_RD && SEC_CFG_IDX == IDX_DIR_HI
        |=> SEC_CFG_RDATA == {$past(pif.dir[7:4]), 4'h0})
        else $error("secondary side read wrong");

    c_pri_dir_write: cover property (CLK_EN && PRI_CFG_WR && PRI_CFG_IDX == IDX_DIR_LO);
    c_sec_val_write: cover property (CLK_EN && SEC_CFG_WR && SEC_CFG_IDX == IDX_VAL_HI);
    c_alt_exit: cover property (alt_mode ##1 !alt_mode);
    c_mask_done: cover property ($rose(MASK_VALID));
endmodule

// ### verification/cgp_board_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// board pins and serial mask shift register
// ----------------------------------------
module cgp_board_model
    import cgp_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic [7:0] ext_drv,
    input wire logic [7:0] ext_en,
    input wire logic [15:0] mask_word,
    output logic [7:0] pin_level,
    output logic ser_out,
    output logic [5:0] shift_count
);
    logic [15:0] shreg;
    logic sclk_q;
    // ----------------------------------------
    // pin level: device driver, board driver, pull-up
    // ----------------------------------------
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (gpio_oe[i]) begin
                pin_level[i] = gpio_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_drv[i];
            end else begin
                pin_level[i] = 1'b1;
            end
        end
    end
    // ----------------------------------------
    // shift register: load while pin 2 low, shift on pin 0 rise
    // ----------------------------------------
    initial begin
        shreg = 16'h0000;
        sclk_q = 1'b1;
        shift_count = 6'h00;
    end
    always @(posedge clk) begin
        if (pin_level[ALT_LOAD_PIN] === 1'b0) begin
            shreg <= mask_word;
            shift_count <= 6'h00;
        end else if (pin_level[ALT_CLK_PIN] === 1'b1 && sclk_q === 1'b0) begin
            // cascade input unused: fill with changing junk
            shreg <= {shreg[14:0], ~shreg[15]};
            shift_count <= shift_count + 6'h01;
        end
        sclk_q <= pin_level[ALT_CLK_PIN];
    end
    assign ser_out = shreg[15];
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb
    import cgp_pkg::*;
;
    logic SYS_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic CLK_EN = 1'b1;
    logic PRIMARY_RESET_INPUT_N = 1'b1;
    logic PRI_CFG_WR = 1'b0;
    logic PRI_CFG_RD = 1'b0;
    logic [2:0] PRI_CFG_IDX = 3'h0;
    logic [7:0] PRI_CFG_WDATA = 8'h00;
    logic SEC_CFG_WR = 1'b0;
    logic SEC_CFG_RD = 1'b0;
    logic [2:0] SEC_CFG_IDX = 3'h0;
    logic [7:0] SEC_CFG_WDATA = 8'h00;
    logic [7:0] ext_drv = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [15:0] mask_word = 16'hc3a5;
    logic [7:0] GPIO_IN, GPIO_OUT, GPIO_OE, PRI_CFG_RDATA, SEC_CFG_RDATA;
    logic [15:0] CLOCK_DISABLE_MASK;
    logic MASK_VALID, ser;
    logic [5:0] shift_count;
    int num_errors = 0;
    int num_checks = 0;
    // ----------------------------------------
    // clock, design and board
    // ----------------------------------------
    always #2.5 SYS_CLK = ~SYS_CLK;
    cgp_top cgp_top_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
        .PRIMARY_RESET_INPUT_N(PRIMARY_RESET_INPUT_N), .MASK_SERIAL_INPUT(ser),
        .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
        .PRI_CFG_WR(PRI_CFG_WR), .PRI_CFG_RD(PRI_CFG_RD), .PRI_CFG_IDX(PRI_CFG_IDX),
        .PRI_CFG_WDATA(PRI_CFG_WDATA), .PRI_CFG_RDATA(PRI_CFG_RDATA),
        .SEC_CFG_WR(SEC_CFG_WR), .SEC_CFG_RD(SEC_CFG_RD), .SEC_CFG_IDX(SEC_CFG_IDX),
        .SEC_CFG_WDATA(SEC_CFG_WDATA), .SEC_CFG_RDATA(SEC_CFG_RDATA),
        .CLOCK_DISABLE_MASK(CLOCK_DISABLE_MASK), .MASK_VALID(MASK_VALID));
    cgp_board_model cgp_board_model_i (.clk(SYS_CLK), .gpio_out(GPIO_OUT),
        .gpio_oe(GPIO_OE), .ext_drv(ext_drv), .ext_en(ext_en), .mask_word(mask_word),
        .pin_level(GPIO_IN), .ser_out(ser), .shift_count(shift_count));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    task automatic cfg_wr(input bit sec, input logic [2:0] idx, input logic [7:0] d);
        settle(1);
        if (sec) begin
            SEC_CFG_WR = 1'b1;
            SEC_CFG_IDX = idx;
            SEC_CFG_WDATA = d;
        end else begin
            PRI_CFG_WR = 1'b1;
            PRI_CFG_IDX = idx;
            PRI_CFG_WDATA = d;
        end
        settle(1);
        PRI_CFG_WR = 1'b0;
        SEC_CFG_WR = 1'b0;
    endtask
    task automatic cfg_rd(input bit sec, input logic [2:0] idx, output logic [7:0] d);
        settle(1);
        if (sec) begin
            SEC_CFG_RD = 1'b1;
            SEC_CFG_IDX = idx;
        end else begin
            PRI_CFG_RD = 1'b1;
            PRI_CFG_IDX = idx;
        end
        settle(1);
        d = sec ? SEC_CFG_RDATA : PRI_CFG_RDATA;
        PRI_CFG_RD = 1'b0;
        SEC_CFG_RD = 1'b0;
    endtask
    task automatic rd_chk(input bit sec, input logic [2:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        cfg_rd(sec, idx, d);
        chk("read data", {8'h00, exp}, {8'h00, d});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_values;
        logic [7:0] exp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hf0, 8'hf0, 8'h00};
        chk("oe after reset", 16'h0000, {8'h00, GPIO_OE});
        chk("out after reset", 16'h0000, {8'h00, GPIO_OUT});
        chk("mask valid", 16'h0000, {15'h0000, MASK_VALID});
        for (int i = 0; i < 7; i++) begin
            rd_chk(i[0], i[2:0], exp[i]);
        end
        $display("done reset_values");
    endtask
    task automatic t_direction;
        bit sd [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [2:0] ix [5] = '{IDX_DIR_LO, IDX_DIR_HI, IDX_DIR_LO, IDX_DIR_LO, IDX_DIR_HI};
        logic [7:0] wd [5] = '{8'h50, 8'h90, 8'h00, 8'h01, 8'h08};
        logic [7:0] oe [5] = '{8'h05, 8'h95, 8'h95, 8'h94, 8'h14};
        for (int i = 0; i < 5; i++) begin
            cfg_wr(sd[i], ix[i], wd[i]);
            settle(1);
            chk("direction", {8'h00, oe[i]}, {8'h00, GPIO_OE});
        end
        rd_chk(1'b0, IDX_DIR_LO, 8'h40);
        rd_chk(1'b1, IDX_DIR_HI, 8'h10);
        $display("done direction");
    endtask
    task automatic t_value;
        ext_en = 8'h21;
        ext_drv = 8'h00;
        cfg_wr(1'b0, IDX_VAL_LO, 8'h50);
        settle(1);
        chk("value set", 16'h0005, {8'h00, GPIO_OUT});
        rd_chk(1'b1, IDX_IN_LO, 8'he0);
        cfg_wr(1'b1, IDX_VAL_LO, 8'h04);
        settle(1);
        chk("value clear", 16'h0001, {8'h00, GPIO_OUT});
        rd_chk(1'b0, IDX_IN_LO, 8'ha0);
        cfg_wr(1'b0, IDX_VAL_LO, 8'h00);
        cfg_wr(1'b0, IDX_IN_LO, 8'hff);
        cfg_wr(1'b1, 3'h6, 8'hff);
        settle(1);
        chk("zero and ro write", 16'h1401, {GPIO_OE, GPIO_OUT});
        rd_chk(1'b1, IDX_IN_HI, 8'hc0);
        rd_chk(1'b0, IDX_VAL_LO, 8'h10);
        $display("done value");
    endtask
    task automatic t_mask;
        int n;
        ext_en = 8'h00;
        cfg_wr(1'b0, IDX_DIR_LO, 8'h05);
        settle(1);
        PRIMARY_RESET_INPUT_N = 1'b0;
        settle(2);
        chk("alt pins driven", 16'h0003, {14'h0000, GPIO_OE[2], GPIO_OE[0]});
        chk("plain pins kept", 16'h0010, {8'h00, GPIO_OE & 8'hfa});
        n = 0;
        while (MASK_VALID !== 1'b1 && n < 400) begin
            settle(1);
            n++;
        end
        settle(2);
        chk("mask", mask_word, CLOCK_DISABLE_MASK);
        chk("shift clocks", 16'h0010, {10'h000, shift_count});
        chk("mask valid", 16'h0001, {15'h0000, MASK_VALID});
        PRIMARY_RESET_INPUT_N = 1'b1;
        settle(2);
        chk("pins back", 16'h1001, {GPIO_OE, GPIO_OUT});
        $display("done mask");
    endtask
    task automatic t_freeze;
        CLK_EN = 1'b0;
        cfg_wr(1'b0, IDX_DIR_LO, 8'h20);
        settle(1);
        chk("frozen oe", 16'h0010, {8'h00, GPIO_OE});
        CLK_EN = 1'b1;
        settle(2);
        chk("write ignored while frozen", 16'h1001, {GPIO_OE, GPIO_OUT});
        $display("done freeze");
    endtask
    // ----------------------------------------
    // verdict, main sequence, watchdog
    // ----------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        settle(5);
        RESETN = 1'b1;
        t_reset_values();
        t_direction();
        t_value();
        t_mask();
        t_freeze();
        summarize();
    end
    initial begin
        #20000;
        num_errors++;
        summarize();
    end
endmodule
